// *** cgo_pkg.sv ***
// Constants for the calibration host controller and its line sequencer.
// Assumes a 20 MHz MCLK, 32-bit APB data and an 8-bit shared pixel bus.
package cgo_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0]  A_CTRL  = 8'h00;
   localparam logic [7:0]  A_CFG   = 8'h04;
   localparam logic [7:0]  A_STAT  = 8'h08;
   localparam logic [7:0]  A_MEAS  = 8'h0C;
   localparam logic [7:0]  A_CADDR = 8'h10;
   localparam logic [7:0]  A_CDATA = 8'h14;
   localparam logic [7:0]  A_LAST  = 8'h18;

   // Control bits
   localparam int CTL_LINE = 0;
   localparam int CTL_CAL  = 1;
   localparam int CTL_CORR = 2;

   // Configuration fields
   localparam int F_GAIN = 0;
   localparam int F_MAG  = 4;
   localparam int F_SIGN = 8;
   localparam int F_ADD  = 9;
   localparam int F_POL  = 10;
   localparam int F_SREF = 12;
   localparam int F_SSIG = 16;
   localparam logic [31:0] CFG_MASK = 32'h000F_F7FF;
   localparam logic [31:0] CFG_RST  = 32'h0000_0000;

   // ************************************************************
   // Pixel stream
   // ************************************************************
   localparam int LINE_PIX  = 256;
   localparam int AVG_SHIFT = 8;
   localparam logic [8:0] LAST_IDX = 9'h0FF;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int MCLK_NS    = 50;
   localparam int PIXEL_CLKS = 8;
   // One clock of code drive: done may fall four clocks after its synced rise
   localparam int DRIVE_NS   = 50;
   localparam int DRIVE_CLKS = DRIVE_NS / MCLK_NS;
   localparam logic [2:0] RD_PH_FIRST  = 3'h1;
   localparam logic [2:0] DRV_PH_FIRST = 3'h2;
   localparam logic [2:0] DRV_PH_LAST  = 3'(DRV_PH_FIRST + DRIVE_CLKS - 1);
   localparam logic [2:0] RD_PH_LAST   = 3'(DRV_PH_LAST + 1);

   // ************************************************************
   // Offset calibration arithmetic
   // ************************************************************
   localparam logic signed [15:0] DAC_BASE  = 16'sh000F;
   localparam logic signed [15:0] DAC_MUL   = 16'sh0027;
   localparam int                 DAC_SHIFT = 5;
   localparam logic signed [15:0] DAC_MAX   = 16'sh000F;
   localparam logic [3:0]         MAG_MAX   = 4'hF;
   localparam logic signed [11:0] ADD_LSB   = 12'sh002;
   localparam logic [7:0]         CODE_UNITY = 8'h00;
   localparam logic [7:0]         CODE_MAXG  = 8'hFF;

   typedef enum logic [1:0] {CAL_IDLE, CAL_UNITY, CAL_MAXG, CAL_CALC} cgo_cal_e;

endpackage : cgo_pkg

// *** cgo_line_seq.sv ***
// Line sequencer: frames one line, captures results, drives codes.
// Assumes the device delivers one result every eight MCLK cycles.
`timescale 1ns/1ps
module cgo_line_seq (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Control
   input  wire logic        start,
   input  wire logic [7:0]  code,
   output logic      [7:0]  pix_idx,
   output logic             busy,
   output logic             line_done,
   output logic      [7:0]  pix_q,
   output logic      [15:0] line_sum,
   // Device pins
   input  wire logic        eoc_b_pin,
   input  wire logic [7:0]  bus_pin,
   output logic             sync_o,
   output logic             rd_b_o,
   output logic      [7:0]  bus_o,
   output logic             bus_oe
);

   logic        eoc_m_r, eoc_s_r, eoc_d_r;
   logic [7:0]  bus_m_r, bus_s_r, q_r, bus_o_r;
   logic [2:0]  ph_r;
   logic [8:0]  cnt_r;
   logic        busy_r, done_r, rd_b_r, oe_r;
   logic [15:0] sum_r;

   wire       eoc_rise = eoc_s_r & ~eoc_d_r;
   wire       cap      = busy_r & eoc_rise;
   // Host ends the line by count
   wire       last     = cap & (cnt_r == cgo_pkg::LAST_IDX);
   wire       busy_nxt = (busy_r & ~last) | start;
   wire [2:0] ph_nxt   = eoc_rise ? 3'h0 : (ph_r == 3'h7 ? ph_r : ph_r + 3'h1);
   wire       drv_nxt  = busy_r & ~last & eoc_s_r & (ph_nxt >= cgo_pkg::DRV_PH_FIRST)
                         & (ph_nxt <= cgo_pkg::DRV_PH_LAST);
   wire       rdh_nxt  = busy_r & eoc_s_r & (ph_nxt >= cgo_pkg::RD_PH_FIRST)
                         & (ph_nxt <= cgo_pkg::RD_PH_LAST);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         eoc_m_r <= 1'b1;
         eoc_s_r <= 1'b1;
         eoc_d_r <= 1'b1;
         bus_m_r <= 8'h00;
         bus_s_r <= 8'h00;
      end else begin
         eoc_m_r <= eoc_b_pin;
         eoc_s_r <= eoc_m_r;
         eoc_d_r <= eoc_s_r;
         bus_m_r <= bus_pin;
         bus_s_r <= bus_m_r;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ph_r    <= 3'h7;
         cnt_r   <= 9'h000;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
         q_r     <= 8'h00;
         sum_r   <= 16'h0000;
         rd_b_r  <= 1'b1;
         oe_r    <= 1'b0;
         bus_o_r <= 8'h00;
      end else begin
         ph_r    <= ph_nxt;
         busy_r  <= busy_nxt;
         done_r  <= last;
         rd_b_r  <= ~busy_nxt | rdh_nxt;
         oe_r    <= drv_nxt;
         bus_o_r <= drv_nxt ? code : 8'h00;
         if (start) begin
            cnt_r <= 9'h000;
            sum_r <= 16'h0000;
         end else if (cap) begin
            cnt_r <= cnt_r + 9'h001;
            sum_r <= sum_r + {8'h00, bus_s_r};
            q_r   <= bus_s_r;
         end
      end
   end

   assign pix_idx   = cnt_r[7:0];
   assign busy      = busy_r;
   assign line_done = done_r;
   assign pix_q     = q_r;
   assign line_sum  = sum_r;
   assign sync_o    = busy_r;
   assign rd_b_o    = rd_b_r;
   assign bus_o     = bus_o_r;
   assign bus_oe    = oe_r;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_drive_when_high: assert property (
      bus_oe |-> $past(eoc_s_r) && rd_b_o && $past(rd_b_o))
      else $error("Code driven outside the high phase");

   chk_line_end_count: assert property (
      last |=> !busy_r && line_done ##1 !sync_o && !line_done)
      else $error("Line did not end after the last pixel");

endmodule : cgo_line_seq

// *** cgo_host_ctrl.sv ***
// Host controller for a linear sensor digitiser: APB registers,
// correction code memory, line framing and offset calibration.
// Assumes the device pins below and APB on the same MCLK.
//
// Operation
// - Coarse gain changes per line only
// - Update config after line or sync low
// - Offset DAC code is static only
// - Capture result on done rising edge
// - Result enable kept off while codes drive
// - Calibrate offset, coarse gain, shading in order; only offset is calibrated here, and coarse gain comes from software
// - First black line: gain 0, DAC max
// - Second black line with code 255
// - DAC code is 15+39*(m1-m2)/32
// - Add bit set when 3*m1 below m2
// - Residual offset (3*m1-m2)/2, plus 2 when add bit set
// - Codes resupplied on every line
`timescale 1ns/1ps
module cgo_host_ctrl (
   // Clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST_B,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic             PREADY,
   output logic      [31:0] PRDATA,
   output logic             PSLVERR,
   // Line framing and shared pixel bus
   output logic             LINE_SYNC,
   input  wire logic        CONV_DONE_B,
   output logic             RESULT_OE_B,
   input  wire logic [7:0]  PIXEL_RESULT_BUS_I,
   output logic      [7:0]  PIXEL_CORRECTION_BUS_O,
   output logic             PIXEL_CORRECTION_BUS_OE,
   // Device configuration
   output logic      [3:0]  CFG_COARSE_GAIN,
   output logic             CFG_POLARITY,
   output logic             CFG_DAC_SIGN,
   output logic      [3:0]  CFG_DAC_MAG,
   output logic             CFG_OFFSET_ADD,
   output logic      [3:0]  CFG_SAMPLE_REF,
   output logic      [3:0]  CFG_SAMPLE_SIG
);

   // ************************************************************
   // State
   // ************************************************************
   logic               pready_r, pslverr_r;
   logic [31:0]        prdata_r, cfg_r;
   logic               corr_en_r, cal_done_r, line_go_r, launched_r;
   logic [7:0]         caddr_r, m1_r, m2_r;
   logic signed [11:0] offs_r;
   logic [3:0]         gain_r, mag_r, sref_r, ssig_r;
   logic               pol_r, sign_r, add_r;
   cgo_pkg::cgo_cal_e  state_r, state_nxt;
   logic [7:0]         coef_mem [0:cgo_pkg::LINE_PIX-1];

   logic [7:0]         pix_idx, pix_q;
   logic [15:0]        line_sum;
   logic               seq_busy, line_done;

   function automatic logic [7:0] line_avg(input logic [15:0] s);
      return 8'(s >> cgo_pkg::AVG_SHIFT);
   endfunction : line_avg

   // ************************************************************
   // APB decode
   // ************************************************************
   wire acc      = PSEL & PENABLE;
   wire first    = acc & ~pready_r;
   wire wr_en    = acc & PWRITE & pready_r;
   wire hit_ctrl = PADDR == cgo_pkg::A_CTRL;
   wire hit_cfg  = PADDR == cgo_pkg::A_CFG;
   wire hit_stat = PADDR == cgo_pkg::A_STAT;
   wire hit_meas = PADDR == cgo_pkg::A_MEAS;
   wire hit_cadr = PADDR == cgo_pkg::A_CADDR;
   wire hit_cdat = PADDR == cgo_pkg::A_CDATA;
   wire hit_last = PADDR == cgo_pkg::A_LAST;
   wire mapped   = hit_ctrl | hit_cfg | hit_stat | hit_meas | hit_cadr | hit_cdat
                   | hit_last;

   wire cal_busy = state_r != cgo_pkg::CAL_IDLE;
   wire [31:0] rd_ctrl = {29'h0, corr_en_r, 2'b00};
   wire [31:0] rd_stat = {29'h0, cal_done_r, cal_busy, seq_busy};
   wire [31:0] rd_meas = {4'h0, offs_r, m2_r, m1_r};
   wire [31:0] rdata   = hit_ctrl ? rd_ctrl :
                         hit_cfg  ? cfg_r :
                         hit_stat ? rd_stat :
                         hit_meas ? rd_meas :
                         hit_cadr ? {24'h0, caddr_r} :
                         hit_cdat ? {24'h0, coef_mem[caddr_r]} :
                         hit_last ? {24'h0, pix_q} : 32'h0000_0000;

   wire go_line_sw = wr_en & hit_ctrl & PWDATA[cgo_pkg::CTL_LINE];
   wire go_cal_sw  = wr_en & hit_ctrl & PWDATA[cgo_pkg::CTL_CAL];

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= first;
         pslverr_r <= first & ~mapped;
         prdata_r  <= (first & ~PWRITE) ? rdata : 32'h0000_0000;
      end
   end

   // ************************************************************
   // Offset calibration arithmetic
   // ************************************************************
   wire signed [15:0] m1x  = $signed({8'h00, m1_r});
   wire signed [15:0] m2x  = $signed({8'h00, m2_r});
   // Integer form of the DAC code
   wire signed [15:0] prod = (m1x - m2x) * cgo_pkg::DAC_MUL;
   wire signed [15:0] dac  = cgo_pkg::DAC_BASE + (prod >>> cgo_pkg::DAC_SHIFT);
   // Result outside the DAC span saturates rather than wraps
   wire signed [15:0] dacc = dac > cgo_pkg::DAC_MAX ? cgo_pkg::DAC_MAX :
                             dac < -cgo_pkg::DAC_MAX ? -cgo_pkg::DAC_MAX : dac;
   wire               sign_calc = dacc < 0;
   wire [3:0]         mag_calc  = 4'(sign_calc ? -dacc : dacc);
   wire signed [11:0] lin3 = 12'(m1x + m1x + m1x - m2x);
   // Add bit when 3*m1 below m2
   wire               add_calc  = lin3 < 0;
   wire signed [11:0] offs_calc = (lin3 >>> 1) + (add_calc ? cgo_pkg::ADD_LSB : 12'sh000);

   // ************************************************************
   // Calibration sequence
   // ************************************************************
   // Offset phase runs as a fixed order
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         cgo_pkg::CAL_IDLE: begin
            if (go_cal_sw && !seq_busy && !line_go_r)
               state_nxt = cgo_pkg::CAL_UNITY;
         end
         cgo_pkg::CAL_UNITY: begin
            if (line_done && launched_r)
               state_nxt = cgo_pkg::CAL_MAXG;
         end
         cgo_pkg::CAL_MAXG: begin
            if (line_done && launched_r)
               state_nxt = cgo_pkg::CAL_CALC;
         end
         cgo_pkg::CAL_CALC: state_nxt = cgo_pkg::CAL_IDLE;
         default: state_nxt = cgo_pkg::CAL_IDLE;
      endcase
   end

   wire cal_line = (state_r == cgo_pkg::CAL_UNITY) | (state_r == cgo_pkg::CAL_MAXG);
   // Black line waits until its setup stands on the pins
   wire cal_set  = (gain_r == 4'h0) & (mag_r == cgo_pkg::MAG_MAX) & ~sign_r & ~add_r;
   wire cal_go   = cal_line & cal_set & ~launched_r & ~seq_busy & ~line_go_r;
   wire sw_go    = go_line_sw & ~cal_busy & ~seq_busy & ~line_go_r;
   // Pins follow software only between lines
   wire pin_upd  = ~seq_busy & ~line_go_r;

   // Unity code on first black line
   wire [7:0] code = (state_r == cgo_pkg::CAL_UNITY) ? cgo_pkg::CODE_UNITY :
                     (state_r == cgo_pkg::CAL_MAXG)  ? cgo_pkg::CODE_MAXG :
                     (corr_en_r & cal_done_r)        ? coef_mem[pix_idx] : 8'h00;

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         state_r    <= cgo_pkg::CAL_IDLE;
         line_go_r  <= 1'b0;
         launched_r <= 1'b0;
         m1_r       <= 8'h00;
         m2_r       <= 8'h00;
         offs_r     <= 12'sh000;
         cal_done_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         line_go_r <= cal_go | sw_go;
         if (cal_go)
            launched_r <= 1'b1;
         else if (line_done)
            launched_r <= 1'b0;
         if (line_done && state_r == cgo_pkg::CAL_UNITY)
            m1_r <= line_avg(line_sum);
         if (line_done && state_r == cgo_pkg::CAL_MAXG)
            m2_r <= line_avg(line_sum);
         if (state_r == cgo_pkg::CAL_CALC)
            offs_r <= offs_calc;
         // Shading codes held back until offset done
         if (state_r == cgo_pkg::CAL_CALC)
            cal_done_r <= 1'b1;
         else if (state_nxt == cgo_pkg::CAL_UNITY && state_r == cgo_pkg::CAL_IDLE)
            cal_done_r <= 1'b0;
      end
   end

   // ************************************************************
   // Software registers and code memory
   // ************************************************************
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         cfg_r     <= cgo_pkg::CFG_RST;
         corr_en_r <= 1'b0;
         caddr_r   <= 8'h00;
      end else begin
         if (wr_en && hit_cfg)
            cfg_r <= PWDATA & cgo_pkg::CFG_MASK;
         // Calibration result becomes the static setting
         if (state_r == cgo_pkg::CAL_CALC) begin
            cfg_r[cgo_pkg::F_MAG +: 4] <= mag_calc;
            cfg_r[cgo_pkg::F_SIGN]     <= sign_calc;
            cfg_r[cgo_pkg::F_ADD]      <= add_calc;
         end
         if (wr_en && hit_ctrl)
            corr_en_r <= PWDATA[cgo_pkg::CTL_CORR];
         if (wr_en && hit_cadr)
            caddr_r <= PWDATA[7:0];
         else if (wr_en && hit_cdat)
            caddr_r <= caddr_r + 8'h01;
      end
   end

   // Whole code set kept for every line
   always_ff @(posedge MCLK) begin
      if (wr_en && hit_cdat)
         coef_mem[caddr_r] <= PWDATA[7:0];
   end

   // ************************************************************
   // Device configuration pins
   // ************************************************************
   // Gain and offset only change between lines
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         gain_r <= 4'h0;
         mag_r  <= 4'h0;
         sign_r <= 1'b0;
         add_r  <= 1'b0;
         pol_r  <= 1'b0;
         sref_r <= 4'h0;
         ssig_r <= 4'h0;
      end else if (pin_upd) begin
         pol_r  <= cfg_r[cgo_pkg::F_POL];
         sref_r <= cfg_r[cgo_pkg::F_SREF +: 4];
         ssig_r <= cfg_r[cgo_pkg::F_SSIG +: 4];
         if (cal_line) begin
            // Gain 0, DAC at +max, no add
            gain_r <= 4'h0;
            mag_r  <= cgo_pkg::MAG_MAX;
            sign_r <= 1'b0;
            add_r  <= 1'b0;
         end else begin
            gain_r <= cfg_r[cgo_pkg::F_GAIN +: 4];
            mag_r  <= cfg_r[cgo_pkg::F_MAG +: 4];
            sign_r <= cfg_r[cgo_pkg::F_SIGN];
            add_r  <= cfg_r[cgo_pkg::F_ADD];
         end
      end
   end

   // ************************************************************
   // Line sequencer
   // ************************************************************
   cgo_line_seq u_seq (
      .clk       (MCLK),
      .rst_b     (RST_B),
      .start     (line_go_r),
      .code      (code),
      .pix_idx   (pix_idx),
      .busy      (seq_busy),
      .line_done (line_done),
      .pix_q     (pix_q),
      .line_sum  (line_sum),
      .eoc_b_pin (CONV_DONE_B),
      .bus_pin   (PIXEL_RESULT_BUS_I),
      .sync_o    (LINE_SYNC),
      .rd_b_o    (RESULT_OE_B),
      .bus_o     (PIXEL_CORRECTION_BUS_O),
      .bus_oe    (PIXEL_CORRECTION_BUS_OE)
   );

   assign PREADY          = pready_r;
   assign PRDATA          = prdata_r;
   assign PSLVERR         = pslverr_r;
   assign CFG_COARSE_GAIN = gain_r;
   assign CFG_POLARITY    = pol_r;
   assign CFG_DAC_SIGN    = sign_r;
   assign CFG_DAC_MAG     = mag_r;
   assign CFG_OFFSET_ADD  = add_r;
   assign CFG_SAMPLE_REF  = sref_r;
   assign CFG_SAMPLE_SIG  = ssig_r;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   sequence s_unity_end;
      state_r == cgo_pkg::CAL_UNITY ##0 line_done ##0 launched_r;
   endsequence

   sequence s_calc_step;
      state_r == cgo_pkg::CAL_CALC;
   endsequence

   chk_cfg_line_hold: assert property (
      seq_busy |-> $stable({gain_r, mag_r, sign_r, add_r, pol_r}))
      else $error("Device configuration changed during a line");

   chk_cfg_sync_low: assert property (
      $changed({gain_r, mag_r, sign_r, add_r}) |-> !LINE_SYNC ##1 !LINE_SYNC)
      else $error("Configuration changed with sync high");

   chk_cal_phase_order: assert property (
      s_unity_end |=> state_r == cgo_pkg::CAL_MAXG && !cal_done_r)
      else $error("Calibration phases out of order");

   chk_unity_setup: assert property (
      (state_r == cgo_pkg::CAL_UNITY && LINE_SYNC) |-> gain_r == 4'h0
         && mag_r == cgo_pkg::MAG_MAX && !sign_r && !add_r
         && (!PIXEL_CORRECTION_BUS_OE || PIXEL_CORRECTION_BUS_O == 8'h00))
      else $error("First black line set up wrongly");

   chk_maxg_code: assert property (
      (state_r == cgo_pkg::CAL_MAXG && PIXEL_CORRECTION_BUS_OE)
         |-> PIXEL_CORRECTION_BUS_O == 8'hFF)
      else $error("Second black line not at full code");

   chk_dac_result: assert property (
      s_calc_step |=> cfg_r[cgo_pkg::F_SIGN] == ($past(dacc) < 0)
         && cfg_r[cgo_pkg::F_MAG +: 4] == 4'($past(sign_calc) ? -$past(dacc) : $past(dacc)))
      else $error("Offset DAC code not written");

   chk_add_choice: assert property (
      (s_calc_step ##0 (3 * m1x > m2x)) |=> !cfg_r[cgo_pkg::F_ADD] ##1 !add_r)
      else $error("Add bit set although 3*m1 exceeds m2");

   chk_offset_value: assert property (
      (s_calc_step ##0 (3 * m1x < m2x)) |=> offs_r == $past(lin3 >>> 1) + 12'sh002)
      else $error("Residual offset misses the added 2");

endmodule : cgo_host_ctrl

// *** cgo_dev_model.sv ***
// Behavioural digitiser seen at its pins: one result per eight clocks.
// Assumes a black input whose level the bench sets through base.
`timescale 1ns/1ps
module cgo_dev_model (
   // Clock and framing
   input  wire logic       clk,
   input  wire logic       sync,
   // Shared bus
   input  wire logic       oe_b,
   input  wire logic       cor_oe,
   input  wire logic [7:0] cor,
   input  wire logic       add,
   input  wire logic [7:0] base,
   output logic            done_b,
   output logic      [7:0] bus,
   output logic            clash
);
   logic [2:0] ph   = 3'h0;
   logic [7:0] code = 8'h00;
   logic [7:0] res  = 8'h00;
   logic [7:0] last = 8'h00;
   int         v;
   initial done_b = 1'b1;
   initial clash = 1'b0;
   always @(posedge clk) begin
      if (cor_oe) code <= cor;
      if (cor_oe && (!done_b || !oe_b)) clash <= 1'b1;
      ph <= sync ? ph + 3'h1 : 3'h0;
      if (sync && ph == 3'h0) begin
         // Code still on the bus at the slot edge belongs to this pixel
         v = base * (256 + 2 * (cor_oe ? cor : code)) / 256 + (add ? 2 : 0);
         res <= (v > 255) ? 8'hFF : v[7:0];
      end
      done_b <= !(sync && ph < 3'h2);
      last <= bus;
   end
   assign bus = !oe_b ? res : (cor_oe ? cor : ~last);
endmodule : cgo_dev_model

// *** cgo_host_ctrl_tb.sv ***
// Self-checking bench for the calibration host controller.
// Assumes cgo_dev_model on the far side of the pixel bus.
`timescale 1ns/1ps
module cgo_host_ctrl_tb;
   logic        MCLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e, add;
   logic [7:0]  PADDR, PIXEL_RESULT_BUS_I, PIXEL_CORRECTION_BUS_O, base;
   logic [31:0] PWDATA, PRDATA, q, cfg, exp_cfg, pins;
   logic        LINE_SYNC, CONV_DONE_B, RESULT_OE_B, PIXEL_CORRECTION_BUS_OE;
   logic        CFG_POLARITY, CFG_DAC_SIGN, CFG_OFFSET_ADD, clash;
   logic [3:0]  CFG_COARSE_GAIN, CFG_DAC_MAG, CFG_SAMPLE_REF, CFG_SAMPLE_SIG;
   int          error_cnt, compares, m1, m2, d, res, codes[256];
   assign pins = {12'h000, CFG_SAMPLE_SIG, CFG_SAMPLE_REF, 1'b0, CFG_POLARITY,
                  CFG_OFFSET_ADD, CFG_DAC_SIGN, CFG_DAC_MAG, CFG_COARSE_GAIN};
   cgo_host_ctrl u_cgo_host_ctrl (.MCLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR,
      .PWDATA, .PREADY, .PRDATA, .PSLVERR, .LINE_SYNC, .CONV_DONE_B, .RESULT_OE_B,
      .PIXEL_RESULT_BUS_I, .PIXEL_CORRECTION_BUS_O, .PIXEL_CORRECTION_BUS_OE,
      .CFG_COARSE_GAIN, .CFG_POLARITY, .CFG_DAC_SIGN, .CFG_DAC_MAG, .CFG_OFFSET_ADD,
      .CFG_SAMPLE_REF, .CFG_SAMPLE_SIG);
   cgo_dev_model u_cgo_dev_model (.clk(MCLK), .sync(LINE_SYNC), .oe_b(RESULT_OE_B),
      .cor_oe(PIXEL_CORRECTION_BUS_OE), .cor(PIXEL_CORRECTION_BUS_O),
      .add(CFG_OFFSET_ADD), .base, .done_b(CONV_DONE_B), .bus(PIXEL_RESULT_BUS_I),
      .clash);
   initial begin
      MCLK = 1'b0;
      forever #25 MCLK = ~MCLK;
   end
   // ****************************************
   // Bus cycles, model and comparisons
   // ****************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      // Wait is unbounded here; the watchdog cuts a hang
      do @(posedge MCLK); while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      // Idle edge so a following call never reassigns PSEL in this step
      @(posedge MCLK);
   endtask : apb
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      compares++;
      if (got !== ex) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic idle(input int b);
      do apb(1'b0, cgo_pkg::A_STAT, 32'h0000_0000); while (q[b] !== 1'b0);
   endtask : idle
   function automatic int pix(input int b, input int c, input logic a);
      int v;
      v = b * (256 + 2 * c) / 256 + (a ? 2 : 0);
      return (v > 255) ? 255 : v;
   endfunction : pix
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (40000) @(posedge MCLK);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      {RST_B, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
      base = 8'h10;
      error_cnt = 0;
      compares = 0;
      void'($urandom(32'hb8984b47));
      repeat (20) @(posedge MCLK);
      chk("oe_b in reset", 32'h0000_0001, {31'h0, RESULT_OE_B});
      RST_B <= 1'b1;
      @(posedge MCLK);
      apb(1'b0, cgo_pkg::A_CFG, 32'h0000_0000);
      chk("cfg reset", cgo_pkg::CFG_RST, q);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, {31'h0, e});
      chk("bad rdata", 32'h0000_0000, q);
      for (int i = 0; i < 4; i++) begin
         cfg = ($urandom & ~32'h0000_0400) | (32'(i % 2) << 10);
         apb(1'b1, cgo_pkg::A_CFG, cfg);
         apb(1'b0, cgo_pkg::A_CFG, 32'h0000_0000);
         chk("cfg read", cfg & cgo_pkg::CFG_MASK, q);
         repeat (2) @(posedge MCLK);
         chk("cfg pins", cfg & cgo_pkg::CFG_MASK, pins);
      end
      base <= 8'(2 + $urandom % 40);
      apb(1'b1, cgo_pkg::A_CTRL, 32'h0000_0002);
      idle(1);
      m1 = pix(base, 0, 1'b0);
      m2 = (m1 + 255 * pix(base, 255, 1'b0)) >> 8;
      d = 15 + ((39 * (m1 - m2)) >>> 5);
      d = (d > 15) ? 15 : ((d < -15) ? -15 : d);
      add = (3 * m1 < m2);
      res = ((3 * m1 - m2) >>> 1) + (add ? 2 : 0);
      apb(1'b0, cgo_pkg::A_MEAS, 32'h0000_0000);
      chk("meas", {4'h0, 12'(res), 8'(m2), 8'(m1)}, q);
      exp_cfg = (cfg & cgo_pkg::CFG_MASK & ~32'h0000_03F0) | (32'((d < 0) ? -d : d) << 4)
                | (32'(d < 0) << 8) | (32'(add) << 9);
      apb(1'b0, cgo_pkg::A_CFG, 32'h0000_0000);
      chk("cal cfg", exp_cfg, q);
      chk("cal pins", exp_cfg, pins);
      apb(1'b0, cgo_pkg::A_STAT, 32'h0000_0000);
      chk("stat", 32'h0000_0004, q & 32'h0000_0007);
      apb(1'b1, cgo_pkg::A_CADDR, 32'h0000_0000);
      for (int i = 0; i < 256; i++) begin
         codes[i] = $urandom % 256;
         apb(1'b1, cgo_pkg::A_CDATA, 32'(codes[i]));
      end
      apb(1'b1, cgo_pkg::A_CADDR, 32'h0000_0005);
      apb(1'b0, cgo_pkg::A_CDATA, 32'h0000_0000);
      chk("code", 32'(codes[5]), q);
      apb(1'b1, cgo_pkg::A_CTRL, 32'h0000_0005);
      // Mid-line write must not reach the pins yet
      apb(1'b1, cgo_pkg::A_CFG, exp_cfg ^ 32'h0000_000F);
      chk("held pins", exp_cfg, pins);
      idle(0);
      apb(1'b0, cgo_pkg::A_LAST, 32'h0000_0000);
      chk("last pixel", 32'(pix(base, codes[255], add)), q);
      repeat (2) @(posedge MCLK);
      chk("new pins", exp_cfg ^ 32'h0000_000F, pins);
      chk("bus clash", 32'h0000_0000, {31'h0, clash});
      tally_and_finish();
   end
endmodule : cgo_host_ctrl_tb
